// ===== rtl/adc_register_bank.sv
// Purpose: Register bank and serial access of a delta-sigma converter.
// Assumes: Core events are one-cycle pulses on clk.
// Notes: Serial pins are sampled by clk, so sclk must stay slow.
// Notes on behaviour
// - Four-bit select picks nine 8/24-bit registers
// - Span calibration overrange sets overflow flag
// - Rate field shows rate of the last result or calibration end
// - Clip-high flag follows result limiting at maximum
// - Clip-low flag follows result limiting at minimum
// - Modulator flag high while converting or calibrating
// - Ready flag sets when result arrives
// - Start clears ready only if result read
// - Read during next conversion clears ready
// - Mains bit picks 50Hz or 60Hz rates
// - Polarity bit picks unipolar or bipolar
// - Clock bit picks external or internal clock
// - Buffer enable bits power buffers up/down
// - Format bit picks bipolar output coding
// - Single-shot converts once then sleeps
// - Continuous mode marks first two results unsettled
// - Command byte: 110, select, write/read bit
// - Data in on rise, out on fall, MSB first
// - Result register ignores writes
module adc_register_bank
    import adc_regs_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Serial pins
    input wire logic sclkPin,
    input wire logic csPinN,
    input wire logic dinPin,
    output logic rdyDoutPin,
    output logic rdyDoutOe,
    // Converter core events
    input wire logic convStart,
    input wire logic calStart,
    input wire logic [RATE_W-1:0] convRate,
    input wire logic resultValid,
    input wire logic [WIDE_W-1:0] resultRaw,
    input wire logic resultClipHigh,
    input wire logic resultClipLow,
    input wire logic calDone,
    input wire logic spanCalOverflow,
    input wire logic powerDownCmd,
    // Calibration write-back
    input wire logic calWrite,
    input wire logic [1:0] calTarget,
    input wire logic [WIDE_W-1:0] calValue,
    // Setup towards the analog side
    output logic mainsSelect,
    output logic unipolarSelect,
    output logic clockSourceSelect,
    output logic refBufferEnable,
    output logic inputBufferEnable,
    output logic singleShotSelect,
    output logic [REG_W-1:0] pinIoSetup,
    output logic [REG_W-1:0] gainCalSetup,
    output logic [WIDE_W-1:0] systemZeroTrim,
    output logic [WIDE_W-1:0] systemSpanTrim,
    output logic [WIDE_W-1:0] selfZeroTrim,
    output logic [WIDE_W-1:0] selfSpanTrim,
    // Converter state
    output logic modulatorActive,
    output logic resultSettled,
    output logic sleepRequest
);

    ////////////////////////////////////////////////////////////////////////
    // Serial front end

    typedef enum logic [4:0] {
        ST_IDLE = 5'b00001,
        ST_CMD = 5'b00010,
        ST_WR = 5'b00100,
        ST_RD = 5'b01000,
        ST_SKIP = 5'b10000
    } spi_state_e;

    spi_state_e state_q;
    spi_state_e state_d;
    logic sclkRise;
    logic sclkFall;
    logic csActive;
    logic dinBit;

    spi_pin_sync u_sync
    (
        .clk(clk),
        .rst_n(rst_n),
        .sclkPin(sclkPin),
        .csPinN(csPinN),
        .dinPin(dinPin),
        .sclkRise(sclkRise),
        .sclkFall(sclkFall),
        .csActive(csActive),
        .dinBit(dinBit)
    );

    logic [CNT_W-1:0] bitCnt_q;
    logic [WIDE_W-1:0] shiftIn_q;
    logic [WIDE_W-1:0] shiftOut_q;
    logic [SEL_W-1:0] sel_q;
    logic firstOut_q;
    logic pinOut_q;
    logic pinOe_q;

    logic [WIDE_W-1:0] inWord;
    logic [REG_W-1:0] cmdByte;
    logic cmdDone;
    logic cmdIsReg;
    logic cmdIsRead;
    logic selWide;
    logic [CNT_W-1:0] lastCnt;
    logic dataDone;
    logic wrStrobe;
    logic readDone;

    assign inWord = {shiftIn_q[WIDE_W-2:0], dinBit};
    assign cmdByte = inWord[REG_W-1:0];
    assign cmdDone = state_q == ST_CMD && sclkRise && bitCnt_q == CNT_CMD_LAST;
    assign cmdIsReg = cmdByte[7:5] == CMD_REG_ACCESS;
    assign cmdIsRead = cmdByte[CMD_RW] == CMD_READ;
    assign selWide = sel_q >= SEL_RESULT && sel_q <= SEL_SELF_SPAN;
    assign lastCnt = selWide ? CNT_WIDE_LAST : CNT_NARROW_LAST;
    assign dataDone = sclkRise && bitCnt_q == lastCnt;
    assign wrStrobe = state_q == ST_WR && dataDone;
    assign readDone = state_q == ST_RD && dataDone && sel_q == SEL_RESULT;

    always_comb
    begin
        state_d = state_q;
        unique case (state_q)
            ST_IDLE:
                if (csActive)
                    state_d = ST_CMD;
            ST_CMD:
                if (cmdDone)
                    state_d = !cmdIsReg ? ST_SKIP : cmdIsRead ? ST_RD : ST_WR;
            ST_WR, ST_RD:
                if (dataDone)
                    state_d = ST_SKIP;
            ST_SKIP:
                state_d = ST_SKIP;
        endcase
        // Raising select aborts any transfer in flight
        if (!csActive)
            state_d = ST_IDLE;
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            state_q <= ST_IDLE;
            bitCnt_q <= '0;
            shiftIn_q <= WIDE_RST;
            sel_q <= SEL_STATUS;
        end
        else
        begin
            state_q <= state_d;
            if (state_d != state_q)
                bitCnt_q <= '0;
            else if (sclkRise)
                bitCnt_q <= bitCnt_q + 5'd1;
            if (sclkRise)
                shiftIn_q <= inWord;
            if (cmdDone)
                sel_q <= cmdByte[4:1];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Register file

    logic [REG_W-1:0] convSetup_q;
    logic [REG_W-1:0] pinIo_q;
    logic [REG_W-1:0] gainCal_q;
    logic [WIDE_W-1:0] trim_q [4];
    logic [WIDE_W-1:0] resultWord;

    // Trim select codes are contiguous from system zero
    logic [1:0] wrTrim;
    logic wrIsTrim;
    logic [SEL_W-1:0] trimOff;

    assign trimOff = sel_q - SEL_SYS_ZERO;
    assign wrTrim = trimOff[1:0];
    assign wrIsTrim = sel_q >= SEL_SYS_ZERO && sel_q <= SEL_SELF_SPAN;

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            convSetup_q <= CONV_RST;
            pinIo_q <= PINIO_RST;
            gainCal_q <= GAINCAL_RST;
        end
        else if (wrStrobe)
        begin
            if (sel_q == SEL_CONV)
                convSetup_q <= inWord[REG_W-1:0] & CONV_WMASK;
            if (sel_q == SEL_PINIO)
                pinIo_q <= inWord[REG_W-1:0];
            if (sel_q == SEL_GAINCAL)
                gainCal_q <= inWord[REG_W-1:0] & GAINCAL_WMASK;
        end
    end

    // Calibration overwrites a host value written in the same cycle
    for (genvar t = 0; t < 4; t++)
    begin : g_trim
        always_ff @(posedge clk)
        begin
            if (!rst_n)
                trim_q[t] <= WIDE_RST;
            else if (calWrite && calTarget == 2'(t))
                trim_q[t] <= calValue;
            else if (wrStrobe && wrIsTrim && wrTrim == 2'(t))
                trim_q[t] <= inWord;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Status tracking

    logic ready_q;
    logic readSeen_q;
    logic startedSince_q;
    logic spanOvf_q;
    logic clipHigh_q;
    logic clipLow_q;
    logic modActive_q;
    logic sleep_q;
    logic [RATE_W-1:0] pendingRate_q;
    logic [RATE_W-1:0] statusRate_q;
    logic anyStart;
    logic freshStart;
    logic [REG_W-1:0] statusByte;

    assign anyStart = convStart | calStart;
    assign freshStart = convStart & ~modActive_q;

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            ready_q <= 1'b0;
            readSeen_q <= 1'b0;
            startedSince_q <= 1'b0;
        end
        else if (resultValid)
        begin
            // A new result wins over any clear in the same cycle
            ready_q <= 1'b1;
            readSeen_q <= 1'b0;
            startedSince_q <= 1'b0;
        end
        else
        begin
            if (convStart)
                startedSince_q <= 1'b1;
            if (readDone)
                readSeen_q <= 1'b1;
            if (convStart && readSeen_q)
                ready_q <= 1'b0;
            if (readDone && (startedSince_q || convStart))
                ready_q <= 1'b0;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            spanOvf_q <= 1'b0;
            clipHigh_q <= 1'b0;
            clipLow_q <= 1'b0;
            pendingRate_q <= '0;
            statusRate_q <= '0;
        end
        else
        begin
            if (calDone)
                spanOvf_q <= spanCalOverflow;
            if (anyStart)
                pendingRate_q <= convRate;
            if (resultValid || calDone)
                statusRate_q <= pendingRate_q;
            if (resultValid)
            begin
                clipHigh_q <= resultClipHigh;
                clipLow_q <= resultClipLow;
            end
        end
    end

    // Start wins over a stop in the same cycle
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            modActive_q <= 1'b0;
            sleep_q <= 1'b0;
        end
        else if (anyStart)
        begin
            modActive_q <= 1'b1;
            sleep_q <= 1'b0;
        end
        else if (calDone || powerDownCmd || (resultValid && singleShotSelect))
        begin
            modActive_q <= 1'b0;
            sleep_q <= powerDownCmd | (resultValid & singleShotSelect);
        end
    end

    assign statusByte = {spanOvf_q, statusRate_q, clipHigh_q, clipLow_q, modActive_q, ready_q};

    result_capture u_result
    (
        .clk(clk),
        .rst_n(rst_n),
        .resultValid(resultValid),
        .resultRaw(resultRaw),
        .freshStart(freshStart),
        .unipolar(unipolarSelect),
        .offsetBinary(convSetup_q[CS_FMT]),
        .singleShot(singleShotSelect),
        .resultWord(resultWord),
        .resultSettled(resultSettled)
    );

    ////////////////////////////////////////////////////////////////////////
    // Read path; narrow registers leave from the top byte

    logic [WIDE_W-1:0] readWord;
    logic [REG_W-1:0] narrowWord;

    assign narrowWord = sel_q == SEL_STATUS ? statusByte
        : sel_q == SEL_CONV ? convSetup_q
        : sel_q == SEL_PINIO ? pinIo_q
        : sel_q == SEL_GAINCAL ? gainCal_q
        : 8'h00;
    assign readWord = sel_q == SEL_RESULT ? resultWord
        : wrIsTrim ? trim_q[wrTrim]
        : {narrowWord, 16'h0000};

    // Idle pin shows ready low while a result waits
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            shiftOut_q <= WIDE_RST;
            firstOut_q <= 1'b1;
            pinOut_q <= 1'b1;
            pinOe_q <= 1'b0;
        end
        else
        begin
            pinOe_q <= csActive;
            if (state_q != ST_RD)
            begin
                firstOut_q <= 1'b1;
                pinOut_q <= ~ready_q;
            end
            else if (sclkFall)
            begin
                firstOut_q <= 1'b0;
                pinOut_q <= firstOut_q ? readWord[WIDE_W-1] : shiftOut_q[WIDE_W-1];
                shiftOut_q <= firstOut_q ? readWord << 1 : shiftOut_q << 1;
            end
        end
    end

    assign rdyDoutPin = pinOut_q;
    assign rdyDoutOe = pinOe_q;

    ////////////////////////////////////////////////////////////////////////
    // Outputs

    assign mainsSelect = convSetup_q[CS_MAINS];
    assign unipolarSelect = convSetup_q[CS_UNI];
    assign clockSourceSelect = convSetup_q[CS_CLK];
    assign refBufferEnable = convSetup_q[CS_REF_BUFFER_ENABLE];
    assign inputBufferEnable = convSetup_q[CS_INBUF];
    assign singleShotSelect = convSetup_q[CS_SINGLE];
    assign pinIoSetup = pinIo_q;
    assign gainCalSetup = gainCal_q;
    assign systemZeroTrim = trim_q[TRIM_SYS_ZERO];
    assign systemSpanTrim = trim_q[TRIM_SYS_SPAN];
    assign selfZeroTrim = trim_q[TRIM_SELF_ZERO];
    assign selfSpanTrim = trim_q[TRIM_SELF_SPAN];
    assign modulatorActive = modActive_q;
    assign sleepRequest = sleep_q;

    ////////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    sequence s_readThenStart;
        readSeen_q && convStart && !resultValid;
    endsequence

    property p_ready_set;
        resultValid |=> ready_q;
    endproperty
    a_ready_set: assert property (p_ready_set) else $error("ready not set");

    property p_start_clears;
        s_readThenStart |=> !ready_q;
    endproperty
    a_start_clears: assert property (p_start_clears) else $error("ready kept");

    property p_unread_keeps;
        ready_q && convStart && !readSeen_q && !readDone && !resultValid |=> ready_q;
    endproperty
    a_unread_keeps: assert property (p_unread_keeps) else $error("ready lost");

    property p_read_clears;
        readDone && startedSince_q && !resultValid |=> !ready_q;
    endproperty
    a_read_clears: assert property (p_read_clears) else $error("ready held");

    property p_clip;
        resultValid |=> clipHigh_q == $past(resultClipHigh) && clipLow_q == $past(resultClipLow);
    endproperty
    a_clip: assert property (p_clip) else $error("clip flags wrong");

    property p_mod_idle;
        (calDone || powerDownCmd) && !anyStart
            |=> !modActive_q ##1 (!modActive_q || $past(anyStart));
    endproperty
    a_mod_idle: assert property (p_mod_idle) else $error("modulator busy");

    property p_rate;
        resultValid |=> statusRate_q == $past(pendingRate_q);
    endproperty
    a_rate: assert property (p_rate) else $error("rate field wrong");

    property p_result_ro;
        wrStrobe && sel_q == SEL_RESULT && !resultValid |=> $stable(resultWord);
    endproperty
    a_result_ro: assert property (p_result_ro) else $error("result written");

    property p_reserved;
        convSetup_q[0] == 1'b0 && gainCal_q[0] == 1'b0;
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved bit set");

    property p_overflow;
        calDone && spanCalOverflow |=> spanOvf_q;
    endproperty
    a_overflow: assert property (p_overflow) else $error("overflow missed");

endmodule

// ===== rtl/adc_regs_pkg.sv
// Purpose: Shared constants of the converter register bank.
// Assumes: Register select codes and reset values as mapped below.
// Notes: Narrow registers are 8 bits, wide ones 24 bits.
package adc_regs_pkg;

    localparam int REG_W = 8;
    localparam int WIDE_W = 24;
    localparam int SEL_W = 4;
    localparam int RATE_W = 3;
    localparam int CNT_W = 5;

    ////////////////////////////////////////////////////////////////////////
    // Register select codes
    localparam logic [3:0] SEL_STATUS = 4'h0;
    localparam logic [3:0] SEL_CONV = 4'h1;
    localparam logic [3:0] SEL_PINIO = 4'h2;
    localparam logic [3:0] SEL_GAINCAL = 4'h3;
    localparam logic [3:0] SEL_RESULT = 4'h4;
    localparam logic [3:0] SEL_SYS_ZERO = 4'h5;
    localparam logic [3:0] SEL_SYS_SPAN = 4'h6;
    localparam logic [3:0] SEL_SELF_ZERO = 4'h7;
    localparam logic [3:0] SEL_SELF_SPAN = 4'h8;

    ////////////////////////////////////////////////////////////////////////
    // Reset values and writable masks
    localparam logic [7:0] CONV_RST = 8'h02;
    localparam logic [7:0] PINIO_RST = 8'h0f;
    localparam logic [7:0] GAINCAL_RST = 8'h1e;
    localparam logic [23:0] WIDE_RST = 24'h000000;
    localparam logic [7:0] CONV_WMASK = 8'hfe;
    localparam logic [7:0] GAINCAL_WMASK = 8'hfe;

    ////////////////////////////////////////////////////////////////////////
    // Field positions of conversion_setup
    localparam int CS_MAINS = 7;
    localparam int CS_UNI = 6;
    localparam int CS_CLK = 5;
    localparam int CS_REF_BUFFER_ENABLE = 4;
    localparam int CS_INBUF = 3;
    localparam int CS_FMT = 2;
    localparam int CS_SINGLE = 1;

    ////////////////////////////////////////////////////////////////////////
    // Command byte layout and bit counts
    localparam logic [2:0] CMD_REG_ACCESS = 3'b110;
    localparam int CMD_RW = 0;
    localparam logic CMD_READ = 1'b1;
    localparam logic [4:0] CNT_CMD_LAST = 5'd7;
    localparam logic [4:0] CNT_NARROW_LAST = 5'd7;
    localparam logic [4:0] CNT_WIDE_LAST = 5'd23;

    // Results after a continuous start up to the first settled one
    localparam logic [1:0] SETTLE_RESULTS = 2'd3;

    // Calibration targets
    localparam logic [1:0] TRIM_SYS_ZERO = 2'd0;
    localparam logic [1:0] TRIM_SYS_SPAN = 2'd1;
    localparam logic [1:0] TRIM_SELF_ZERO = 2'd2;
    localparam logic [1:0] TRIM_SELF_SPAN = 2'd3;

endpackage

// ===== rtl/result_capture.sv
// Purpose: Hold the conversion result in its output format.
// Assumes: Raw results arrive as offset binary.
// Notes: Only the converter core loads it; the serial side cannot.
module result_capture
    import adc_regs_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Core side
    input wire logic resultValid,
    input wire logic [WIDE_W-1:0] resultRaw,
    input wire logic freshStart,
    input wire logic unipolar,
    input wire logic offsetBinary,
    input wire logic singleShot,
    // Held result
    output logic [WIDE_W-1:0] resultWord,
    output logic resultSettled
);

    logic [1:0] settleCnt_q;
    logic flipMsb;

    // Unipolar ignores the format bit
    assign flipMsb = ~unipolar & ~offsetBinary;

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            resultWord <= WIDE_RST;
            settleCnt_q <= 2'd0;
        end
        else
        begin
            if (resultValid)
                resultWord <= resultRaw ^ {flipMsb, {(WIDE_W-1){1'b0}}};
            if (freshStart)
                settleCnt_q <= 2'd0;
            else if (resultValid && settleCnt_q != SETTLE_RESULTS)
                settleCnt_q <= settleCnt_q + 2'd1;
        end
    end

    assign resultSettled = singleShot | (settleCnt_q == SETTLE_RESULTS);

endmodule

// ===== rtl/spi_pin_sync.sv
// Purpose: Bring the serial pins into the clk domain, find clock edges.
// Assumes: Pins are asynchronous to clk and slower than clk / 4.
// Notes: Edges are one-cycle pulses gated by chip select.
module spi_pin_sync
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Pins
    input wire logic sclkPin,
    input wire logic csPinN,
    input wire logic dinPin,
    // Synchronised view
    output logic sclkRise,
    output logic sclkFall,
    output logic csActive,
    output logic dinBit
);

    logic [2:0] meta_q;
    logic [2:0] sync_q;
    logic sclkPrev_q;

    // Stage one is read only by stage two
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            meta_q <= 3'h1;
            sync_q <= 3'h1;
            sclkPrev_q <= 1'b0;
        end
        else
        begin
            meta_q <= {dinPin, sclkPin, csPinN};
            sync_q <= meta_q;
            sclkPrev_q <= sync_q[1];
        end
    end

    assign csActive = ~sync_q[0];
    assign dinBit = sync_q[2];
    assign sclkRise = csActive & sync_q[1] & ~sclkPrev_q;
    assign sclkFall = csActive & ~sync_q[1] & sclkPrev_q;

endmodule

// ===== testbench/adc_register_map_status_control_test.sv
// Purpose: Self-checking bench of the converter register bank.
// Assumes: Host model drives the pins; core events are driven here.
// Notes: Modulator status follows starts, single-shot results and calibration ends.
module adc_register_map_status_control_test
    import adc_regs_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic clk = '0;
    logic rst_n = '0;
    logic sclkPin, csPinN, dinPin, rdyDoutPin, rdyDoutOe;
    logic convStart = '0, calStart = '0, resultValid = '0, calDone = '0, calWrite = '0;
    logic resultClipHigh = '0, resultClipLow = '0, spanCalOverflow = '0, powerDownCmd = '0;
    logic [RATE_W-1:0] convRate = '0;
    logic [WIDE_W-1:0] resultRaw = '0, calValue = '0;
    logic [1:0] calTarget = '0;
    logic mainsSelect, unipolarSelect, clockSourceSelect, refBufferEnable, inputBufferEnable;
    logic singleShotSelect, modulatorActive, resultSettled, sleepRequest;
    logic [REG_W-1:0] pinIoSetup, gainCalSetup;
    logic [WIDE_W-1:0] systemZeroTrim, systemSpanTrim, selfZeroTrim, selfSpanTrim;
    logic [23:0] mdl [9];
    logic [23:0] setups [3] = '{24'h2, 24'h6, 24'h42};
    logic [23:0] q;
    logic seenDone;
    logic rdy = '0, span_cal_overflow = '0, clipH = '0, clipL = '0, running = '0, wasRead = '0;
    logic [2:0] rate = '0, pend = '0;
    logic [31:0] rnd = 32'h3316;
    int failCount = 0, nCompared = 0;

    adc_register_bank DUT
    (
        .clk, .rst_n, .sclkPin, .csPinN, .dinPin, .rdyDoutPin, .rdyDoutOe, .convStart,
        .calStart, .convRate, .resultValid, .resultRaw, .resultClipHigh, .resultClipLow,
        .calDone, .spanCalOverflow, .powerDownCmd, .calWrite, .calTarget, .calValue,
        .mainsSelect, .unipolarSelect, .clockSourceSelect, .refBufferEnable,
        .inputBufferEnable, .singleShotSelect, .pinIoSetup, .gainCalSetup, .systemZeroTrim,
        .systemSpanTrim, .selfZeroTrim, .selfSpanTrim, .modulatorActive, .resultSettled,
        .sleepRequest
    );

    spi_host_model host
    (
        .sclkPin, .csPinN, .dinPin, .rdyDoutPin
    );

    always #4 clk = ~clk;

    ////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] nxt(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction

    function automatic logic [23:0] expOf(input logic [3:0] s);
        if (s == SEL_STATUS)
            return {16'h0, span_cal_overflow, rate, clipH, clipL, running, rdy};
        return (s < 4'h9) ? mdl[s] : 24'h0;
    endfunction

    task automatic tick();
        @(posedge clk);
        #1;
    endtask

    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        nCompared++;
        if (got !== exp)
        begin
            failCount++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic acc(input logic [3:0] s, input logic wr, input logic [23:0] d);
        int w;
        w = (s inside {[4:8]}) ? 24 : 8;
        if (w == 8)
            d[23:8] = '0;
        host.xfer({CMD_REG_ACCESS, s, wr ? ~CMD_READ : CMD_READ}, d, w, q);
        if (wr && s inside {[1:3], [5:8]})
            mdl[s] = (s == 2 || s > 4) ? d : d & 24'hfe;
        if (!wr && s == SEL_RESULT && running)
            rdy = '0;
        else if (!wr && s == SEL_RESULT)
            wasRead = 1'h1;
    endtask

    task automatic rdc(input logic [3:0] s);
        logic [23:0] e;
        e = expOf(s);
        acc(s, '0, '0);
        chk(q, e);
    endtask

    task automatic start(input logic [2:0] r);
        convRate = r;
        convStart = 1'h1;
        tick();
        convStart = '0;
        rdy = wasRead ? 1'h0 : rdy;
        wasRead = '0;
        running = 1'h1;
        pend = r;
        chk(24'(modulatorActive), 24'h1);
    endtask

    task automatic result(input logic hi, input logic lo);
        rnd = nxt(rnd);
        resultRaw = rnd[23:0];
        resultClipHigh = hi;
        resultClipLow = lo;
        resultValid = 1'h1;
        tick();
        resultValid = '0;
        mdl[4] = (mdl[1][CS_UNI] || mdl[1][CS_FMT]) ? rnd[23:0] : rnd[23:0] ^ 24'h800000;
        {rdy, running, wasRead, rate, clipH, clipL} = {3'b100, pend, hi, lo};
    endtask

    task automatic tallyAndFinish();
        $display("compared %0d mismatched %0d", nCompared, failCount);
        if (failCount == 0 && nCompared > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        mdl = '{24'h0, 24'h2, 24'hf, 24'h1e, 24'h0, 24'h0, 24'h0, 24'h0, 24'h0};
        repeat (2) tick();
        rst_n = 1'h1;
        repeat (3) tick();
        for (int s = 0; s < 16; s++)
            rdc(s[3:0]);
        for (int s = 0; s < 9; s++)
        begin
            rnd = nxt(rnd);
            acc(s[3:0], 1'h1, rnd[23:0]);
        end
        for (int s = 0; s < 9; s++)
            rdc(s[3:0]);
        chk(24'({mainsSelect, unipolarSelect, clockSourceSelect, refBufferEnable,
            inputBufferEnable, singleShotSelect}), {mdl[1][7:3], mdl[1][1]});
        chk(24'(pinIoSetup), mdl[2]);
        chk(24'(gainCalSetup), mdl[3]);
        chk(systemZeroTrim ^ systemSpanTrim, mdl[5] ^ mdl[6]);
        chk(selfZeroTrim ^ selfSpanTrim, mdl[7] ^ mdl[8]);
        for (int k = 0; k < 3; k++)
        begin
            acc(SEL_CONV, 1'h1, setups[k]);
            start(3'(k + 1));
            rdc(SEL_STATUS);
            result(k == 1, k == 2);
            rdc(SEL_STATUS);
            rdc(SEL_RESULT);
        end
        chk(24'(resultSettled), 24'h1);
        chk(24'(sleepRequest), 24'h1);
        result('0, '0);
        start(3'h6);
        rdc(SEL_STATUS);
        rdc(SEL_RESULT);
        rdc(SEL_STATUS);
        fork
            host.waitDone(200, seenDone);
            begin
                repeat (40) tick();
                result('0, '0);
            end
        join
        chk(24'(seenDone), 24'h1);
        rdc(SEL_RESULT);
        convRate = 3'h5;
        calStart = 1'h1;
        tick();
        calStart = '0;
        spanCalOverflow = 1'h1;
        calDone = 1'h1;
        tick();
        {calDone, spanCalOverflow, span_cal_overflow, rate, running} = {3'b001, 3'h5, 1'b0};
        rdc(SEL_STATUS);
        rnd = nxt(rnd);
        {calTarget, calValue} = rnd[25:0];
        calWrite = 1'h1;
        tick();
        calWrite = '0;
        mdl[5 + calTarget] = calValue;
        rdc(4'(5 + calTarget));
        // Continuous mode: settled only after the filter has flushed
        acc(SEL_CONV, 1'h1, 24'h0);
        start(3'h2);
        chk(24'(sleepRequest), 24'h0);
        repeat (2) result('0, '0);
        chk(24'(resultSettled), 24'h0);
        result('0, '0);
        chk(24'(resultSettled), 24'h1);
        chk(24'(modulatorActive), 24'h1);
        tallyAndFinish();
    end

    // Bounded guard against a hung run
    initial
    begin
        repeat (60000) @(posedge clk);
        failCount++;
        tallyAndFinish();
    end
endmodule

// ===== testbench/spi_host_model.sv
// Purpose: Host serial master that drives the register bank pins.
// Assumes: Clock idles low, data set on falls, sampled on rises, 160 ns period.
// Notes: The serial clock stands still between frames.
module spi_host_model
(
    // Serial pins
    output logic sclkPin,
    output logic csPinN,
    output logic dinPin,
    input wire logic rdyDoutPin
);
    timeunit 1ns;
    timeprecision 1ps;

    initial
    begin
        sclkPin = '0;
        csPinN = 1'h1;
        dinPin = 1'h1;
    end

    ////////////////////////////////////////////////////////////////////////
    // One whole access per select low, command then w data bits
    task automatic xfer(input logic [7:0] cmd, input logic [23:0] wr, input int w,
        output logic [23:0] rd);
        logic [31:0] word;
        word = ({24'h0, cmd} << w) | {8'h0, wr};
        rd = '0;
        csPinN = '0;
        #80;
        for (int i = w + 7; i >= 0; i--)
        begin
            dinPin = word[i];
            #80;
            sclkPin = 1'h1;
            rd = {rd[22:0], rdyDoutPin};
            #80;
            sclkPin = '0;
        end
        #80;
        csPinN = 1'h1;
        // Released line shows the inverse so a stale bit cannot pass
        dinPin = ~dinPin;
        if (w == 8)
            rd[23:8] = '0;
        #160;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Hold select low and watch the pin until a waiting result shows
    task automatic waitDone(input int limit, output logic seen);
        seen = '0;
        csPinN = '0;
        for (int i = 0; i < limit && !seen; i++)
        begin
            #8;
            seen = rdyDoutPin === '0;
        end
        csPinN = 1'h1;
        #160;
    endtask
endmodule
